// file: nco_monitor.sv
/*
  concurrent checks on the oscillator top ports, bound into nco_top.
  assumes the apb and sample stream ports exactly as nco_top declares them.
*/
`timescale 1ns/100ps
module nco_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic [nco_pkg::SAMPLES_PER_CLOCK*nco_pkg::SAMPLE_BITS-1:0] cos_samples,
  input wire logic [nco_pkg::SAMPLES_PER_CLOCK*nco_pkg::SAMPLE_BITS-1:0] sin_samples
);
  // ----------------------------------------------------------------
  // helper terms
  // ----------------------------------------------------------------
  // lane 0 power, widened so full scale squared cannot overflow
  logic signed [33:0] c0;
  logic signed [33:0] s0;
  logic [33:0] pow0;
  logic mapped;
  // sign-extend on purpose into the wide product terms
  assign c0 = 34'(signed'(cos_samples[15:0]));
  assign s0 = 34'(signed'(sin_samples[15:0]));
  assign pow0 = c0 * c0 + s0 * s0;
  assign mapped = paddr inside {nco_pkg::CTRL_OFFSET, nco_pkg::STEP_OFFSET, nco_pkg::SHIFT_OFFSET,
    nco_pkg::STATUS_OFFSET, nco_pkg::PHASE_OFFSET};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_hold_group;
    sample_valid && !sample_ready |=> $stable(cos_samples) && $stable(sin_samples);
  endproperty
  a_hold_group: assert property (p_hold_group) else $error("sample group changed while stalled");
  property p_hold_valid;
    sample_valid && !sample_ready |=> sample_valid;
  endproperty
  a_hold_valid: assert property (p_hold_valid) else $error("valid dropped while stalled");
  property p_start;
    $rose(presetn) |-> ##[1:3] sample_valid;
  endproperty
  a_start: assert property (p_start) else $error("no samples after reset release");
  property p_no_min;
    sample_valid |-> cos_samples[15:0] != 16'h8000 && sin_samples[15:0] != 16'h8000;
  endproperty
  a_no_min: assert property (p_no_min) else $error("lane 0 at most negative code");
  property p_power;
    sample_valid |-> pow0 > 34'd1030000000 && pow0 < 34'd1117000000;
  endproperty
  a_power: assert property (p_power) else $error("lane 0 magnitude off full scale");
  property p_err_set;
    psel && penable && !mapped |-> pslverr;
  endproperty
  a_err_set: assert property (p_err_set) else $error("unmapped access without error");
  property p_err_only;
    pslverr |-> psel && penable && !mapped;
  endproperty
  a_err_only: assert property (p_err_only) else $error("error outside unmapped access");
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access cycle not ready");
endmodule
bind nco_top nco_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sample_valid(sample_valid), .sample_ready(sample_ready), .cos_samples(cos_samples),
  .sin_samples(sin_samples));

// file: nco_pkg.sv
/*
  constants shared by the numerically controlled oscillator: widths, lane count,
  register offsets, field positions and reset values.
  assumes it is compiled before every other file of the block.
*/
package nco_pkg;

  // ----------------------------------------------------------------
  // datapath widths
  // ----------------------------------------------------------------
  localparam int ACCUMULATOR_BITS = 32;   // allowed 4 .. 32
  localparam int LOOKUP_ANGLE_BITS = 10;  // allowed 4 .. 16
  localparam int SAMPLES_PER_CLOCK = 4;   // allowed 1 .. 16
  localparam int SAMPLE_BITS = 16;        // allowed 4 .. 32

  // quarter-wave table: two angle bits select the quadrant
  localparam int QUARTER_BITS = LOOKUP_ANGLE_BITS - 2;
  localparam int QUARTER_DEPTH = 1 << QUARTER_BITS;
  localparam longint FULL_SCALE = (64'sd1 <<< (SAMPLE_BITS - 1)) - 64'sd1;
  localparam longint HALF_PI_Q30 = 64'sd1686629713;  // pi/2 in 2.30 fixed point
  localparam int Q_FRAC = 30;

  typedef logic [SAMPLE_BITS-1:0] nco_rom_t [0:QUARTER_DEPTH-1];

  // least spacing between phase-step changes in multi-sample mode
  localparam int STEP_GAP = SAMPLES_PER_CLOCK / 2 + 1;
  localparam logic [4:0] STEP_GAP_CNT = 5'(STEP_GAP);

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STEP_OFFSET = 8'h04;
  localparam logic [7:0] SHIFT_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;
  localparam logic [7:0] PHASE_OFFSET = 8'h10;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam int STATUS_CLOSE_BIT = 0;   // sticky, write one to clear
  localparam int STATUS_RUN_BIT = 1;     // read only

  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam logic [ACCUMULATOR_BITS-1:0] INITIAL_PHASE_STEP = 32'h0100_0000;
  localparam logic [ACCUMULATOR_BITS-1:0] INITIAL_PHASE_SHIFT = 32'h0000_0000;

endpackage

// file: nco_sincos_lookup.sv
/*
  one lane of the sine/cosine lookup: a quarter-wave constant table addressed
  directly by the angle, with quadrant folding and a registered signed output.
  assumes the angle is a register on the same clock; load advances the output.
*/
`timescale 1ns/100ps
module nco_sincos_lookup (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [nco_pkg::LOOKUP_ANGLE_BITS-1:0] angle,
  output logic signed [nco_pkg::SAMPLE_BITS-1:0] cos_out,
  output logic signed [nco_pkg::SAMPLE_BITS-1:0] sin_out
);

  // ----------------------------------------------------------------
  // table build
  // ----------------------------------------------------------------
  // sampled at half-step centres so both quadrant halves mirror exactly
  function automatic nco_pkg::nco_rom_t nco_build();
    nco_pkg::nco_rom_t r;
    longint x;
    longint x2;
    longint t;
    longint s;
    longint v;
    for (int k = 0; k < nco_pkg::QUARTER_DEPTH; k++) begin
      x = (longint'(2 * k + 1) * nco_pkg::HALF_PI_Q30) / longint'(2 * nco_pkg::QUARTER_DEPTH);
      x2 = (x * x) >>> nco_pkg::Q_FRAC;
      t = x;
      s = x;
      t = -((t * x2) >>> nco_pkg::Q_FRAC) / 6;
      s = s + t;
      t = -((t * x2) >>> nco_pkg::Q_FRAC) / 20;
      s = s + t;
      t = -((t * x2) >>> nco_pkg::Q_FRAC) / 42;
      s = s + t;
      t = -((t * x2) >>> nco_pkg::Q_FRAC) / 72;
      s = s + t;
      v = (s * nco_pkg::FULL_SCALE + (64'sd1 <<< (nco_pkg::Q_FRAC - 1))) >>> nco_pkg::Q_FRAC;
      if (v > nco_pkg::FULL_SCALE) begin
        v = nco_pkg::FULL_SCALE;
      end
      r[k] = nco_pkg::SAMPLE_BITS'(v);
    end
    return r;
  endfunction

  localparam nco_pkg::nco_rom_t QUARTER_TABLE = nco_build();

  // ----------------------------------------------------------------
  // quadrant folding
  // ----------------------------------------------------------------
  // R4: direct angle address
  wire [nco_pkg::QUARTER_BITS-1:0] idx_fwd = angle[nco_pkg::QUARTER_BITS-1:0];
  wire [nco_pkg::QUARTER_BITS-1:0] idx_rev = ~angle[nco_pkg::QUARTER_BITS-1:0];
  wire quad_lo = angle[nco_pkg::LOOKUP_ANGLE_BITS-2];
  wire quad_hi = angle[nco_pkg::LOOKUP_ANGLE_BITS-1];
  wire [nco_pkg::SAMPLE_BITS-1:0] sin_mag = quad_lo ? QUARTER_TABLE[idx_rev] : QUARTER_TABLE[idx_fwd];
  wire [nco_pkg::SAMPLE_BITS-1:0] cos_mag = quad_lo ? QUARTER_TABLE[idx_fwd] : QUARTER_TABLE[idx_rev];
  // cosine is the sine one quadrant ahead
  wire sin_neg = quad_hi;
  wire cos_neg = quad_hi ^ quad_lo;
  // R8: amplitude is full scale, the largest positive code
  wire [nco_pkg::SAMPLE_BITS-1:0] sin_next = sin_neg ? (~sin_mag + 1'b1) : sin_mag;
  wire [nco_pkg::SAMPLE_BITS-1:0] cos_next = cos_neg ? (~cos_mag + 1'b1) : cos_mag;

  // output register, held while the stream stalls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cos_out <= '0;
      sin_out <= '0;
    end else if (load) begin
      cos_out <= signed'(cos_next);
      sin_out <= signed'(sin_next);
    end
  end

endmodule

// file: nco_sink_model.sv
/*
  downstream sample sink: takes whole groups, stalling three of four cycles when slow.
  assumes the oscillator stream on pclk with valid/ready.
*/
`timescale 1ns/100ps
module nco_sink_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_valid,
  input wire logic slow,
  output logic sample_ready
);
  // ----------------------------------------------------------------
  // stall pattern
  // ----------------------------------------------------------------
  logic [1:0] cnt_reg;
  // counts only while offered, so stalls always land on live groups
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 2'h0;
    end else if (sample_valid) begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
  assign sample_ready = !slow || cnt_reg == 2'h0;
endmodule

// file: nco_top.sv
/*
  numerically controlled oscillator: phase accumulator, phase shift, several
  sine/cosine lanes per clock and an apb register file.
  assumes an apb master on pclk and a downstream sink with valid/ready.
*/
// Overview of operation
// R1: several parallel samples every clock cycle
// R2: step changes need spacing of N cycles
// R3: accumulator width sets frequency resolution
// R4: lookup addressed directly by angle bits
// R5: outputs are signed words of parameter width
// R6: phase advances by step per sample
// R7: shift added to phase before lookup
// R8: outputs scale cos and sin to full scale
// R9: accumulator wraps; starts from initial values
`timescale 1ns/100ps
module nco_top #(
  parameter logic [nco_pkg::ACCUMULATOR_BITS-1:0] initial_phase_step = nco_pkg::INITIAL_PHASE_STEP,
  parameter logic [nco_pkg::ACCUMULATOR_BITS-1:0] initial_phase_shift = nco_pkg::INITIAL_PHASE_SHIFT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic sample_valid,
  input wire logic sample_ready,
  output logic [nco_pkg::SAMPLES_PER_CLOCK*nco_pkg::SAMPLE_BITS-1:0] cos_samples,
  output logic [nco_pkg::SAMPLES_PER_CLOCK*nco_pkg::SAMPLE_BITS-1:0] sin_samples
);

  localparam int AW = nco_pkg::ACCUMULATOR_BITS;
  localparam int LW = nco_pkg::LOOKUP_ANGLE_BITS;
  localparam int SPC = nco_pkg::SAMPLES_PER_CLOCK;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic enable_reg;
  logic [AW-1:0] step_reg;
  logic [AW-1:0] shift_reg;
  logic [AW-1:0] acc_reg;
  logic close_reg;
  logic [4:0] gap_reg;
  logic stepped_reg;
  logic lane_valid_reg;
  logic out_valid_reg;
  logic [LW-1:0] angle_reg [0:SPC-1];
  logic [31:0] prdata_reg;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // zero wait states: every access completes in its first access cycle
  wire setup_cycle = psel && !penable;
  wire access_cycle = psel && penable;
  wire hit_ctrl = (paddr == nco_pkg::CTRL_OFFSET);
  wire hit_step = (paddr == nco_pkg::STEP_OFFSET);
  wire hit_shift = (paddr == nco_pkg::SHIFT_OFFSET);
  wire hit_status = (paddr == nco_pkg::STATUS_OFFSET);
  wire hit_phase = (paddr == nco_pkg::PHASE_OFFSET);
  wire hit_any = hit_ctrl || hit_step || hit_shift || hit_status || hit_phase;
  wire wr_ok = access_cycle && pwrite && hit_any;
  wire wr_ctrl = wr_ok && hit_ctrl;
  wire wr_step = wr_ok && hit_step;
  wire wr_shift = wr_ok && hit_shift;
  wire wr_status = wr_ok && hit_status;
  wire restart = wr_ctrl && pwdata[nco_pkg::CTRL_RESTART_BIT];

  assign pready = 1'b1;
  assign pslverr = access_cycle && !hit_any;
  assign prdata = prdata_reg;

  // read mux; unmapped addresses read as zero
  wire [31:0] ctrl_view = {{31{1'b0}}, enable_reg};
  wire [31:0] status_view = {{30{1'b0}}, out_valid_reg, close_reg};
  wire [31:0] read_next = hit_ctrl ? ctrl_view :
                          hit_step ? 32'(step_reg) :
                          hit_shift ? 32'(shift_reg) :
                          hit_status ? status_view :
                          hit_phase ? 32'(acc_reg) : 32'h0000_0000;

  // read data is captured in the setup cycle so it is a register at access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_cycle) begin
      prdata_reg <= read_next;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // R9: start from the configured step and shift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= nco_pkg::CTRL_ENABLE_RESET;
      step_reg <= initial_phase_step;
      shift_reg <= initial_phase_shift;
    end else begin
      if (wr_ctrl) begin
        enable_reg <= pwdata[nco_pkg::CTRL_ENABLE_BIT];
      end
      if (wr_step) begin
        step_reg <= pwdata[AW-1:0];
      end
      if (wr_shift) begin
        shift_reg <= pwdata[AW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // step spacing watch
  // ----------------------------------------------------------------
  // R2: flag step writes closer than the gap
  wire too_close = wr_step && stepped_reg && (gap_reg < nco_pkg::STEP_GAP_CNT);
  wire close_clear = wr_status && pwdata[nco_pkg::STATUS_CLOSE_BIT];
  wire [4:0] gap_next = wr_step ? 5'h01 :
                        (gap_reg < nco_pkg::STEP_GAP_CNT) ? gap_reg + 5'h01 : gap_reg;

  // a violation in the clearing cycle still sets the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_reg <= 5'h00;
      stepped_reg <= 1'b0;
      close_reg <= 1'b0;
    end else begin
      gap_reg <= gap_next;
      stepped_reg <= stepped_reg || wr_step;
      close_reg <= too_close || (close_reg && !close_clear);
    end
  end

  // ----------------------------------------------------------------
  // phase accumulator and lane angles
  // ----------------------------------------------------------------
  // the pipeline only moves when the sink can take the held group
  wire advance = !out_valid_reg || sample_ready;
  // R3: wrap modulo the accumulator width
  wire [AW-1:0] group_step = AW'(step_reg * SPC);
  wire [AW-1:0] acc_next = restart ? {AW{1'b0}} :
                           (advance && enable_reg) ? acc_reg + group_step : acc_reg;

  // R9: modular accumulator with restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // lane k sits k steps past the group base, so one step value serves the whole
  // group and a step change takes effect on a group boundary without a glitch
  genvar k;
  generate
    for (k = 0; k < SPC; k++) begin : g_lane
      // R6: lane phase k steps ahead
      wire [AW-1:0] lane_offset = AW'(step_reg * k);
      // R7: shift added before lookup
      wire [AW-1:0] lane_phase = acc_reg + lane_offset + shift_reg;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          angle_reg[k] <= '0;
        end else if (advance) begin
          angle_reg[k] <= lane_phase[AW-1 -: LW];
        end
      end

      // R5: signed lane words
      nco_sincos_lookup u_lookup (
        .pclk(pclk),
        .presetn(presetn),
        .load(advance),
        .angle(angle_reg[k]),
        .cos_out(cos_samples[k*nco_pkg::SAMPLE_BITS +: nco_pkg::SAMPLE_BITS]),
        .sin_out(sin_samples[k*nco_pkg::SAMPLE_BITS +: nco_pkg::SAMPLE_BITS])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // stream valid tracking
  // ----------------------------------------------------------------
  // R1: one whole group per accepted cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_valid_reg <= 1'b0;
      out_valid_reg <= 1'b0;
    end else if (advance) begin
      lane_valid_reg <= enable_reg && !restart;
      out_valid_reg <= lane_valid_reg;
    end
  end

  assign sample_valid = out_valid_reg;

endmodule

// file: numerically_controlled_oscillator_test.sv
/*
  self-checking bench for nco_top: apb register calls and sample group checks.
  assumes nco_pkg defaults and the sink model on the stream side.
*/
`timescale 1ns/100ps
module numerically_controlled_oscillator_test;
  // ----------------------------------------------------------------
  // signals and state
  // ----------------------------------------------------------------
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, sample_valid, sample_ready, e;
  logic [63:0] cos_samples, sin_samples;
  int num_errors = 0, checks = 0, cycles = 0, exp_a = -1, d = 4, prev = -1, tc[1024], ts[1024];
  bit chk_on = 0;
  logic [31:0] shifts[5] = '{32'h0, 32'h4000_0000, 32'h8000_0000, 32'hc000_0000, 32'h1234_5678};
  nco_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .cos_samples(cos_samples),
    .sin_samples(sin_samples));
  nco_sink_model u_sink (.pclk(pclk), .presetn(presetn), .sample_valid(sample_valid), .slow(slow),
    .sample_ready(sample_ready));
  always #4 pclk = ~pclk;
  // hang guard, generous against roughly seven hundred cycles of tests
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 4000) begin
      num_errors++;
      report_and_stop;
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task report_and_stop;
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task check_val(input string n, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, ex, got);
    end
  endtask
  // table rounding differs by a code or two, so samples get a small window
  task check_near(input string n, input int ex, input logic signed [15:0] got);
    checks++;
    if ($isunknown(got) || int'(got) > ex + 2 || int'(got) < ex - 2) begin
      num_errors++;
      $display("BAD %s expected %0d seen %0d", n, ex, got);
    end
  endtask
  // one transfer; caller sits just after an edge and releases with idle
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
  endtask
  task idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
    idle;
  endtask
  task rd(input string n, input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    idle;
    check_val(n, ex, r);
  endtask
  function automatic int ab(input int x);
    return x < 0 ? -x : x;
  endfunction
  // ----------------------------------------------------------------
  // group checker: measure lane 0 angle, then every lane and the next group
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    int a0, best, err;
    if (presetn && chk_on && sample_valid === 1'b1 && sample_ready === 1'b1) begin
      a0 = exp_a;
      best = 1 << 30;
      // always measure lane 0, so a known angle is compared and not assumed
      for (int a = 0; a < 1024; a++) begin
        err = ab(int'(signed'(cos_samples[15:0])) - tc[a]) + ab(int'(signed'(sin_samples[15:0])) - ts[a]);
        if (err < best) begin
          best = err;
          a0 = a;
        end
      end
      if (exp_a >= 0) check_val("shift angle", exp_a, a0);
      if (prev >= 0) check_val("group angle", (prev + 4 * d) % 1024, a0);
      for (int k = 0; k < 4; k++) begin
        check_near("cos lane", tc[(a0 + k * d) % 1024], cos_samples[16*k +: 16]);
        check_near("sin lane", ts[(a0 + k * d) % 1024], sin_samples[16*k +: 16]);
      end
      prev = a0;
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int a = 0; a < 1024; a++) begin
      tc[a] = int'($cos(2.0 * 3.14159265358979 * (a + 0.5) / 1024.0) * 32767.0);
      ts[a] = int'($sin(2.0 * 3.14159265358979 * (a + 0.5) / 1024.0) * 32767.0);
    end
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl", nco_pkg::CTRL_OFFSET, 32'h1);
    rd("step", nco_pkg::STEP_OFFSET, nco_pkg::INITIAL_PHASE_STEP);
    rd("shift", nco_pkg::SHIFT_OFFSET, nco_pkg::INITIAL_PHASE_SHIFT);
    slow <= 1'b1;
    chk_on = 1;
    repeat (200) @(posedge pclk);
    rd("unmapped", 8'h14, 32'h0);
    check_val("unmapped error", 32'h1, {31'h0, e});
    chk_on = 0;
    wr(nco_pkg::STEP_OFFSET, 32'h0);
    wr(nco_pkg::CTRL_OFFSET, 32'h3);
    rd("phase after restart", nco_pkg::PHASE_OFFSET, 32'h0);
    d = 0;
    // frozen accumulator, so every lane shows the shift alone
    foreach (shifts[i]) begin
      chk_on = 0;
      prev = -1;
      wr(nco_pkg::SHIFT_OFFSET, shifts[i]);
      repeat (12) @(posedge pclk);
      exp_a = int'(shifts[i][31:22]);
      chk_on = 1;
      repeat (20) @(posedge pclk);
    end
    exp_a = -1;
    // a coarse step, then the largest one, which wraps on every group
    for (int i = 0; i < 2; i++) begin
      chk_on = 0;
      prev = -1;
      d = i == 0 ? 47 : 1023;
      wr(nco_pkg::STEP_OFFSET, 32'(d) << 22);
      repeat (12) @(posedge pclk);
      chk_on = 1;
      repeat (100) @(posedge pclk);
    end
    chk_on = 0;
    // step writes 2, 3, 4 cycles apart against the minimum spacing
    for (int g = 0; g < 3; g++) begin
      apb(1'b1, nco_pkg::STEP_OFFSET, 32'h0100_0000);
      repeat (g) idle;
      wr(nco_pkg::STEP_OFFSET, 32'hffc0_0000);
      rd("status", nco_pkg::STATUS_OFFSET, {30'h0, 1'b1, 1'(2 + g < nco_pkg::STEP_GAP)});
      wr(nco_pkg::STATUS_OFFSET, 32'h1);
    end
    wr(nco_pkg::CTRL_OFFSET, 32'h0);
    slow <= 1'b0;
    repeat (10) @(posedge pclk);
    check_val("valid when off", 32'h0, {31'h0, sample_valid});
    wr(nco_pkg::CTRL_OFFSET, 32'h1);
    repeat (5) @(posedge pclk);
    check_val("valid when on", 32'h1, {31'h0, sample_valid});
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check_val("valid in reset", 32'h0, {31'h0, sample_valid});
    presetn <= 1'b1;
    rd("step after reset", nco_pkg::STEP_OFFSET, nco_pkg::INITIAL_PHASE_STEP);
    report_and_stop;
  end
endmodule
